// File: gsp_panel_logic.sv
// front-panel mode, lock, leak test and set-point relay logic
`timescale 1ns/1ns
module gsp_panel_logic
  import gsp_pkg::*;
#(
  parameter int HOLD_CYCLES = HOLD_CYC,
  parameter int RPT_CYCLES = RPT_CYC,
  parameter int BEEP_CYCLES = BEEP_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // operator controls
  input wire gsp_func_t func_sel,
  input wire logic [2:0] gauge_sel,
  input wire gsp_keys_t keys,
  // sensor channels
  input wire gsp_chan_t [NCH-1:0] chan,
  input wire logic single_a,
  input wire logic single_b,
  // relays
  output logic [NCH-1:0] relay_coil,
  output logic [NCH-1:0] relay_energized_lamps,
  // display
  output gsp_msg_t [NCH-1:0] line_msg,
  output logic [PW-1:0] sp_shown,
  output logic [2*NSEG-1:0] bar_graph,
  output logic beep_out,
  output logic remote,
  output logic proc_suspend,
  output logic comm_lock,
  output logic cal_lock,
  // nonvolatile store
  output logic nv_wr,
  output logic [2:0] nv_idx,
  output logic [PW-1:0] nv_data
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    gsp_keys_t keys_prev;
    gsp_func_t func_prev;
    logic [2:0] sel_prev;
    logic [NCH-1:0][PW-1:0] sp;
    logic [PW-1:0] edit;
    logic dirty;
    logic [31:0] hold_cnt;
    gsp_lock_st_t lk;
    logic [2:0] lk_cnt;
    logic locked;
    logic toggled;
    logic [PW-1:0] ref_p;
    logic beep_en;
    logic [31:0] beep_cnt;
    logic beep_out;
    logic [2*NSEG-1:0] bar;
    logic [NCH-1:0] relay;
    gsp_msg_t [NCH-1:0] msgs;
    logic nv_wr;
    logic [2:0] nv_idx;
    logic [PW-1:0] nv_data;
    logic powered;
    logic comm_lock;
    logic cal_lock;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } gsp_state_t;

  gsp_state_t s_reg;
  gsp_state_t s_next;
  gsp_func_t fn;
  gsp_keys_t pr;
  gsp_keys_t rel;
  logic edit_ok;
  logic [PW-1:0] selp;

  // ----------------------------------------------------------------
  // decoders
  // ----------------------------------------------------------------
  function automatic logic sel_ok(input logic [2:0] sel);
    sel_ok = sel < 3'(NCH);
  endfunction : sel_ok

  function automatic logic leak_ok(input gsp_chan_t c);
    leak_ok = c.present && c.kind != KIND_CAP;
  endfunction : leak_ok

  function automatic logic [2:0] relay_src(input int i, input logic sa, input logic sb);
    logic [2:0] r;
    r = 3'(i);
    if (r == CH_A2 && sa) r = CH_A1;
    if (r == CH_B2 && sb) r = CH_B1;
    relay_src = r;
  endfunction : relay_src

  function automatic gsp_msg_t chan_msg(input gsp_chan_t c);
    gsp_msg_t m;
    m = MSG_PRESS;
    if (!c.present) m = MSG_NONE;
    else if (c.kind == KIND_CC && c.ctl_trip) m = MSG_CTL;
    else if (c.kind == KIND_CC && c.pro_trip) m = MSG_PRO;
    else if (c.kind == KIND_CC && c.cc_off) m = MSG_OFF;
    else if (c.kind == KIND_CAP && c.below0) m = MSG_ERR;
    else if (c.hi) m = (c.kind == KIND_PIR) ? MSG_AA : MSG_HI;
    else if (c.lo) m = MSG_LO;
    chan_msg = m;
  endfunction : chan_msg

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [PW-1:0] mag;
    logic pos;
    logic lit;
    logic rep;
    logic [3:0] lvl;
    logic [31:0] period;
    logic [2:0] src;
    logic leak_on;
    gsp_msg_t m;
    mag = '0;
    pos = 1'b0;
    lit = 1'b0;
    period = 32'h0;
    src = 3'h0;
    leak_on = 1'b0;
    m = MSG_PRESS;
    s_next = s_reg;
    pr = gsp_keys_t'(keys & ~s_reg.keys_prev);
    rel = gsp_keys_t'(~keys & s_reg.keys_prev);
    fn = s_reg.locked ? FN_PRESS : func_sel;
    edit_ok = 1'b0;
    rep = 1'b0;
    lvl = 4'h0;
    s_next.keys_prev = keys;
    s_next.nv_wr = 1'b0;
    s_next.powered = 1'b1;
    selp = sel_ok(gauge_sel) ? chan[gauge_sel].press : SP_OFF;

    // lock sequence runs even when locked so it can unlock
    case (s_reg.lk)
      LK_IDLE: begin
        if (fn == FN_PRESS && gauge_sel == SEL_BOTTOM && keys.up) begin
          if (pr.down) s_next.lk_cnt = s_reg.lk_cnt + 3'h1;
          if (pr.down && s_reg.lk_cnt == LOCK_PRESSES - 3'h1) s_next.lk = LK_SHOW;
        end else begin
          s_next.lk_cnt = 3'h0;
        end
      end
      LK_SHOW: begin
        if (pr.down) begin
          s_next.lk = LK_ARM;
          s_next.toggled = 1'b0;
        end
      end
      LK_ARM: begin
        if (keys.down && pr.up && !s_reg.toggled) begin
          s_next.locked = !s_reg.locked;
          s_next.toggled = 1'b1;
        end
        if (rel.down) s_next.lk = LK_DONE;
      end
      LK_DONE: begin
        if (pr.up) begin
          s_next.lk = LK_IDLE;
          s_next.lk_cnt = 3'h0;
        end
      end
      default: s_next.lk = LK_IDLE;
    endcase

    // set point edit: relays use the stored copy, never the edit
    s_next.func_prev = fn;
    s_next.sel_prev = gauge_sel;
    if (fn != s_reg.func_prev || gauge_sel != s_reg.sel_prev) begin
      if (s_reg.dirty && s_reg.func_prev == FN_RELAY && sel_ok(s_reg.sel_prev)) begin
        s_next.sp[s_reg.sel_prev] = s_reg.edit;
        s_next.nv_wr = 1'b1;
        s_next.nv_idx = s_reg.sel_prev;
        s_next.nv_data = s_reg.edit;
      end
      s_next.dirty = 1'b0;
      s_next.hold_cnt = 32'h0;
      s_next.edit = selp;
      if (sel_ok(gauge_sel)) s_next.edit = s_reg.sp[gauge_sel];
    end else if (fn == FN_RELAY && s_reg.lk == LK_IDLE && sel_ok(gauge_sel)) begin
      edit_ok = 1'b1;
      if (keys.up ^ keys.down) begin
        if (s_reg.hold_cnt >= 32'(HOLD_CYCLES)) begin
          rep = 1'b1;
          s_next.hold_cnt = 32'(HOLD_CYCLES - RPT_CYCLES);
        end else begin
          s_next.hold_cnt = s_reg.hold_cnt + 32'h1;
        end
      end else begin
        s_next.hold_cnt = 32'h0;
      end
      if (pr.up || (rep && keys.up)) begin
        s_next.dirty = 1'b1;
        if (s_reg.edit == SP_OFF) s_next.edit = SP_MIN;
        else if (s_reg.edit < SP_MAX) s_next.edit = s_reg.edit + SP_STEP;
      end else if (pr.down || (rep && keys.down)) begin
        s_next.dirty = 1'b1;
        if (s_reg.edit > SP_MIN) s_next.edit = s_reg.edit - SP_STEP;
        else if (pr.down) s_next.edit = SP_OFF;
      end
    end

    // leak test
    leak_on = fn == FN_LEAK && sel_ok(gauge_sel) && leak_ok(chan[gauge_sel]);
    if (fn == FN_LEAK && s_reg.lk == LK_IDLE) begin
      if (pr.beeper) s_next.beep_en = !s_reg.beep_en;
      if (pr.zero) s_next.ref_p = selp;
    end
    pos = selp > s_reg.ref_p;
    mag = pos ? selp - s_reg.ref_p : s_reg.ref_p - selp;
    s_next.bar = '0;
    // each segment needs twice the deviation of the one inside it
    for (int k = 0; k < NSEG; k++) begin
      lit = leak_on && mag >= (PW'(1) << k);
      s_next.bar[NSEG + k] = lit && pos;
      s_next.bar[NSEG - 1 - k] = lit && !pos;
      if (lit) lvl = lvl + 4'h1;
    end
    period = 32'(BEEP_CYCLES) >> lvl;
    s_next.beep_cnt = (s_reg.beep_cnt >= period - 32'h1) ? 32'h0 : s_reg.beep_cnt + 32'h1;
    s_next.beep_out = leak_on && s_reg.beep_en && s_reg.beep_cnt < (period >> 1);

    // relays are evaluated in every mode
    for (int i = 0; i < NCH; i++) begin
      src = relay_src(i, single_a, single_b);
      s_next.relay[i] = chan[src].present && s_reg.sp[i] != SP_OFF &&
        chan[src].press < s_reg.sp[i];
    end

    // display lines
    for (int i = 0; i < NCH; i++) begin
      case (fn)
        FN_PRESS: m = chan_msg(chan[i]);
        FN_LEAK: begin
          m = MSG_PRESS;
          if (!leak_on) begin
            if (3'(i) == gauge_sel) m = MSG_NONE;
            else m = leak_ok(chan[i]) ? MSG_LEAK_OK : MSG_BLANK;
          end
        end
        FN_RELAY: begin
          if (!chan[i].present) m = (3'(i) == gauge_sel) ? MSG_NONE : MSG_BLANK;
          else m = (3'(i) == gauge_sel) ? MSG_SETPT : MSG_PRESS;
        end
        default: m = chan[i].present ? MSG_PRESS : MSG_NONE;
      endcase
      if (s_reg.lk != LK_IDLE && i == 0) m = s_reg.locked ? MSG_FROZEN : MSG_FREE;
      s_next.msgs[i] = m;
    end

    // axi4-lite write: address and data in either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_next.aw_got = 1'b1;
      s_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_next.w_got = 1'b1;
      s_next.wdata = s_axi_wdata;
      s_next.wstrb = s_axi_wstrb;
    end
    if (s_reg.aw_got && s_reg.w_got) begin
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = RESP_SLVERR;
      if (s_reg.awaddr == ADDR_CTRL) begin
        s_next.bresp = RESP_OKAY;
        if (s_reg.wstrb[0]) begin
          s_next.comm_lock = s_reg.wdata[CTRL_COMM];
          s_next.cal_lock = s_reg.wdata[CTRL_CAL];
          s_next.beep_en = s_reg.wdata[CTRL_BEEP];
        end
      end
    end
    if (s_reg.bvalid && s_axi_bready) s_next.bvalid = 1'b0;

    // axi4-lite read
    if (s_axi_arvalid && s_axi_arready) begin
      s_next.rvalid = 1'b1;
      s_next.rresp = RESP_OKAY;
      s_next.rdata = 32'h0;
      if (s_axi_araddr == ADDR_STATUS) begin
        s_next.rdata[STAT_LOCK] = s_reg.locked;
        s_next.rdata[STAT_SUSP] = proc_suspend;
        s_next.rdata[STAT_BEEP] = s_reg.beep_en;
        s_next.rdata[STAT_FN +: 2] = fn;
      end else if (s_axi_araddr == ADDR_CTRL) begin
        s_next.rdata[CTRL_COMM] = s_reg.comm_lock;
        s_next.rdata[CTRL_CAL] = s_reg.cal_lock;
        s_next.rdata[CTRL_BEEP] = s_reg.beep_en;
      end else if (s_axi_araddr == ADDR_RELAY) begin
        s_next.rdata[NCH-1:0] = s_reg.relay;
      end else if (s_axi_araddr >= ADDR_SP0 && s_axi_araddr < ADDR_SP_END &&
          s_axi_araddr[1:0] == 2'h0) begin
        s_next.rdata[PW-1:0] = s_reg.sp[3'((s_axi_araddr - ADDR_SP0) >> 2)];
      end else begin
        s_next.rresp = RESP_SLVERR;
      end
    end
    if (s_reg.rvalid && s_axi_rready) s_next.rvalid = 1'b0;

    // first cycle after power-on; the panel lock is left alone
    if (!s_reg.powered && func_sel == FN_LEAK) begin
      s_next.comm_lock = 1'b0;
      s_next.cal_lock = 1'b0;
    end
  end

  // all-zero reset also gives every set point the disabled code
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = !s_reg.aw_got && !s_reg.bvalid;
  assign s_axi_wready = !s_reg.w_got && !s_reg.bvalid;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_arready = !s_reg.rvalid;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;
  assign relay_coil = s_reg.relay;
  assign relay_energized_lamps = s_reg.relay;
  assign line_msg = s_reg.msgs;
  assign sp_shown = s_reg.edit;
  assign bar_graph = s_reg.bar;
  assign beep_out = s_reg.beep_out;
  assign remote = s_reg.locked;
  assign proc_suspend = s_reg.lk == LK_SHOW || s_reg.lk == LK_ARM;
  assign comm_lock = s_reg.comm_lock;
  assign cal_lock = s_reg.cal_lock;
  assign nv_wr = s_reg.nv_wr;
  assign nv_idx = s_reg.nv_idx;
  assign nv_data = s_reg.nv_data;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_relay_on;
    @(posedge clk) disable iff (reset)
    (chan[0].present && s_reg.sp[0] != SP_OFF && chan[0].press < s_reg.sp[0]) |=> relay_coil[0];
  endproperty
  a_relay_on: assert property (p_relay_on)
    else $error("relay 0 not energised below set point");

  property p_lamp;
    @(posedge clk) disable iff (reset)
    relay_energized_lamps == relay_coil;
  endproperty
  a_lamp: assert property (p_lamp)
    else $error("lamp differs from relay");

  property p_commit;
    @(posedge clk) disable iff (reset)
    nv_wr |-> $past(s_reg.dirty) && s_reg.sp[nv_idx] == nv_data;
  endproperty
  a_commit: assert property (p_commit)
    else $error("store without applied edit");

  property p_factory;
    @(posedge clk) disable iff (reset)
    !s_reg.powered |-> s_reg.sp == '0;
  endproperty
  a_factory: assert property (p_factory)
    else $error("set points not disabled after reset");

  property p_disable;
    @(posedge clk) disable iff (reset)
    (edit_ok && s_reg.edit == SP_MIN && pr.down && !keys.up) |=> s_reg.edit == SP_OFF;
  endproperty
  a_disable: assert property (p_disable)
    else $error("down at bottom did not disable");

  property p_restore;
    @(posedge clk) disable iff (reset)
    (edit_ok && s_reg.edit == SP_OFF && pr.up) |=> s_reg.edit == SP_MIN;
  endproperty
  a_restore: assert property (p_restore)
    else $error("up from disabled did not restore");

  property p_once;
    @(posedge clk) disable iff (reset)
    (s_reg.lk == LK_ARM && s_reg.toggled) |=> $stable(s_reg.locked);
  endproperty
  a_once: assert property (p_once)
    else $error("lock toggled twice");

  property p_locked;
    @(posedge clk) disable iff (reset)
    s_reg.locked |-> fn == FN_PRESS && !edit_ok;
  endproperty
  a_locked: assert property (p_locked)
    else $error("locked panel left pressure mode");

  property p_show;
    @(posedge clk) disable iff (reset)
    (s_reg.lk == LK_IDLE && fn == FN_PRESS && gauge_sel == SEL_BOTTOM && keys.up &&
      pr.down && s_reg.lk_cnt == LOCK_PRESSES - 3'h1)
      |=> s_reg.lk == LK_SHOW ##1 (line_msg[0] == MSG_FROZEN || line_msg[0] == MSG_FREE);
  endproperty
  a_show: assert property (p_show)
    else $error("lock status not shown");

  property p_poweron;
    @(posedge clk) disable iff (reset)
    (!s_reg.powered && func_sel == FN_LEAK) |=> !comm_lock && !cal_lock;
  endproperty
  a_poweron: assert property (p_poweron)
    else $error("locks not cleared at power-on");

endmodule : gsp_panel_logic

// File: gsp_pkg.sv
// shared constants and types of the gauge set-point and panel logic
package gsp_pkg;
  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NCH = 5;
  localparam int PW = 16;
  localparam int NSEG = 13;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ = 100_000;
  localparam int HOLD_MS = 500;
  localparam int RPT_MS = 50;
  localparam int BEEP_MS = 1200;
  localparam int HOLD_CYC = HOLD_MS * CLK_KHZ;
  localparam int RPT_CYC = RPT_MS * CLK_KHZ;
  localparam int BEEP_CYC = BEEP_MS * CLK_KHZ;
  // ----------------------------------------------------------------
  // set point codes (log-coded pressure, larger is higher pressure)
  // ----------------------------------------------------------------
  localparam logic [PW-1:0] SP_OFF = 16'h0000;
  localparam logic [PW-1:0] SP_MIN = 16'h0100;
  localparam logic [PW-1:0] SP_MAX = 16'hFF00;
  localparam logic [PW-1:0] SP_STEP = 16'h0001;
  // ----------------------------------------------------------------
  // channels and lock sequence
  // ----------------------------------------------------------------
  localparam logic [2:0] CH_A1 = 3'h1;
  localparam logic [2:0] CH_A2 = 3'h2;
  localparam logic [2:0] CH_B1 = 3'h3;
  localparam logic [2:0] CH_B2 = 3'h4;
  localparam logic [2:0] SEL_BOTTOM = 3'h4;
  localparam logic [2:0] LOCK_PRESSES = 3'h4;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_RELAY = 8'h08;
  localparam logic [7:0] ADDR_SP0 = 8'h10;
  localparam logic [7:0] ADDR_SP_END = 8'h24;
  localparam int CTRL_COMM = 0;
  localparam int CTRL_CAL = 1;
  localparam int CTRL_BEEP = 2;
  localparam int STAT_LOCK = 0;
  localparam int STAT_SUSP = 1;
  localparam int STAT_BEEP = 2;
  localparam int STAT_FN = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {FN_PRESS, FN_LEAK, FN_RELAY, FN_PROT} gsp_func_t;
  typedef enum logic [2:0] {KIND_CC, KIND_PIR, KIND_CONV, KIND_TC, KIND_CAP} gsp_kind_t;
  typedef enum logic [3:0] {MSG_PRESS, MSG_NONE, MSG_BLANK, MSG_CTL, MSG_PRO, MSG_OFF,
    MSG_HI, MSG_LO, MSG_AA, MSG_ERR, MSG_LEAK_OK, MSG_SETPT, MSG_FROZEN,
    MSG_FREE} gsp_msg_t;
  typedef enum logic [1:0] {LK_IDLE, LK_SHOW, LK_ARM, LK_DONE} gsp_lock_st_t;
  typedef struct packed {
    logic present;
    gsp_kind_t kind;
    logic hi;
    logic lo;
    logic below0;
    logic cc_off;
    logic ctl_trip;
    logic pro_trip;
    logic [PW-1:0] press;
  } gsp_chan_t;
  typedef struct packed {
    logic up;
    logic down;
    logic zero;
    logic beeper;
  } gsp_keys_t;
endpackage : gsp_pkg

// File: gsp_sensor_bank.sv
// behavioural sensor bank and relay contact model beside the panel logic
`timescale 1ns/1ns
module gsp_sensor_bank
  import gsp_pkg::*;
(
  // clock
  input wire logic clk,
  // readings asked for by the bench, coils from the panel
  input wire gsp_chan_t [NCH-1:0] want,
  input wire logic [NCH-1:0] coil,
  // sensor readings and relay contacts
  output gsp_chan_t [NCH-1:0] chan,
  output logic [NCH-1:0] contact_no,
  output logic [NCH-1:0] contact_nc
);
  // a sensor updates once a clock, so a new reading lands one edge late
  always_ff @(posedge clk) chan <= want;
  // changeover contact pair follows the coil
  assign contact_no = coil;
  assign contact_nc = ~coil;
endmodule : gsp_sensor_bank

// File: tb_gsp_panel_logic.sv
// self-checking testbench of the gauge panel and set-point logic
`timescale 1ns/1ns
module tb_gsp_panel_logic
  import gsp_pkg::*;
;
  // ----
  // signals
  // ----
  logic clk, reset, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  gsp_func_t func_sel;
  logic [2:0] gauge_sel, nv_idx;
  gsp_keys_t keys;
  gsp_chan_t [NCH-1:0] want, chan;
  logic single_a, single_b, beep_out, remote, proc_suspend, comm_lock, cal_lock, nv_wr;
  logic [NCH-1:0] relay_coil, relay_energized_lamps, contact_no, contact_nc;
  gsp_msg_t [NCH-1:0] line_msg;
  logic [PW-1:0] sp_shown, nv_data;
  logic [2*NSEG-1:0] bar_graph;
  logic [18:0] nv_last;
  int mismatches = 0, samples_checked = 0, n, nv_cnt = 0;
  int mch [7] = '{0, 0, 0, 3, 3, 1, 4};
  logic [5:0] mfl [7] = '{6'h05, 6'h06, 6'h04, 6'h20, 6'h10, 6'h20, 6'h08};
  gsp_msg_t mexp [7] = '{MSG_PRO, MSG_CTL, MSG_OFF, MSG_HI, MSG_LO, MSG_AA, MSG_ERR};
  logic [7:0] regs [8] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20};
  gsp_panel_logic #(.HOLD_CYCLES(20), .RPT_CYCLES(4), .BEEP_CYCLES(64)) gsp_panel_logic_inst (
    .clk(clk), .reset(reset), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .func_sel(func_sel), .gauge_sel(gauge_sel), .keys(keys), .chan(chan), .single_a(single_a),
    .single_b(single_b), .relay_coil(relay_coil), .relay_energized_lamps(relay_energized_lamps),
    .line_msg(line_msg), .sp_shown(sp_shown), .bar_graph(bar_graph), .beep_out(beep_out),
    .remote(remote), .proc_suspend(proc_suspend), .comm_lock(comm_lock), .cal_lock(cal_lock),
    .nv_wr(nv_wr), .nv_idx(nv_idx), .nv_data(nv_data));
  gsp_sensor_bank gsp_sensor_bank_inst (.clk(clk), .want(want), .coil(relay_coil),
    .chan(chan), .contact_no(contact_no), .contact_nc(contact_nc));
  // store pulses are one cycle wide, so they are caught here rather than by the sequence
  always @(posedge clk) if (nv_wr === 1'h1) begin
    nv_last <= {nv_idx, nv_data};
    nv_cnt <= nv_cnt + 1;
  end
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // ----
  // tasks
  // ----
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
      mismatches++;
    end
  endtask : chk
  task automatic lapse;
    mismatches++;
    give_verdict();
  endtask : lapse
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic pa, pw, ta, tw;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    pa = 1'h1;
    pw = 1'h1;
    for (n = 0; pa || pw; n++) begin
      if (n == 50) lapse();
      @(negedge clk);
      ta = pa && s_axi_awready;
      tw = pw && s_axi_wready;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      pa = pa && !ta;
      pw = pw && !tw;
    end
    for (n = 0; s_axi_bvalid !== 1'h1; n++) begin
      if (n == 50) lapse();
      @(negedge clk);
    end
    resp = s_axi_bresp;
    @(posedge clk);
    s_axi_bready <= 1'h0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (n = 0; s_axi_arready !== 1'h1 || n == 0; n++) begin
      if (n == 50) lapse();
      @(negedge clk);
    end
    @(posedge clk);
    s_axi_arvalid <= 1'h0;
    for (n = 0; s_axi_rvalid !== 1'h1 || n == 0; n++) begin
      if (n == 50) lapse();
      @(negedge clk);
    end
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    @(posedge clk);
    s_axi_rready <= 1'h0;
  endtask : axi_rd
  task automatic put(input logic [3:0] k, input int cyc);
    @(posedge clk);
    keys <= k;
    repeat (cyc) @(posedge clk);
    @(negedge clk);
  endtask : put
  task automatic tap(input logic [3:0] hold, input logic [3:0] k);
    put(hold | k, 2);
    put(hold, 2);
  endtask : tap
  task automatic sel(input gsp_func_t f, input logic [2:0] g);
    @(posedge clk);
    func_sel <= f;
    gauge_sel <= g;
    repeat (4) @(negedge clk);
  endtask : sel
  initial begin
    {reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {48'h0, 4'hF};
    func_sel = FN_PRESS;
    {gauge_sel, keys, single_a, single_b} = 9'h0;
    for (int i = 0; i < NCH; i++) want[i] = {1'h1, 3'(i), 6'h00, 16'h8000};
    repeat (10) @(posedge clk);
    reset <= 1'h0;
    for (int i = 0; i < 8; i++) begin
      axi_rd(regs[i]);
      chk("reset value", rd, 32'h0);
    end
    axi_rd(8'h0C);
    chk("unmapped rresp", resp, RESP_SLVERR);
    axi_wr(ADDR_CTRL, 32'h3);
    chk("lock bits", {cal_lock, comm_lock}, 2'h3);
    axi_wr(ADDR_RELAY, 32'h1F);
    chk("read-only bresp", resp, RESP_SLVERR);
    axi_wr(ADDR_CTRL, 32'h0);
    want[0].press <= 16'h0050;
    sel(FN_RELAY, 3'h0);
    tap(4'h0, 4'h8);
    chk("up from off", sp_shown, 16'h0100);
    tap(4'h0, 4'h8);
    chk("up step", sp_shown, 16'h0101);
    chk("not yet applied", relay_coil[0], 1'h0);
    sel(FN_RELAY, 3'h1);
    chk("stored", nv_last, {3'h0, 16'h0101});
    chk("coil", relay_coil[0], 1'h1);
    chk("lamp", relay_energized_lamps[0], 1'h1);
    chk("nc contact", contact_nc[0], 1'h0);
    axi_rd(ADDR_SP0);
    chk("applied", rd, 32'h0101);
    want[0].press <= 16'h0200;
    repeat (4) @(negedge clk);
    chk("coil above", relay_coil[0], 1'h0);
    want[0].press <= 16'h0050;
    sel(FN_RELAY, 3'h0);
    chk("review only", nv_cnt, 1);
    tap(4'h0, 4'h8);
    put(4'h4, 40);
    chk("held at bottom", sp_shown, 16'h0100);
    put(4'h0, 2);
    tap(4'h0, 4'h4);
    chk("disabled", sp_shown, 16'h0000);
    sel(FN_RELAY, 3'h1);
    chk("disabled coil", relay_coil[0], 1'h0);
    tap(4'h0, 4'h8);
    put(4'h8, 40);
    chk("repeat", sp_shown > 16'h0102, 1'h1);
    put(4'h0, 2);
    sel(FN_RELAY, 3'h2);
    tap(4'h0, 4'h8);
    want[1].press <= 16'h0050;
    sel(FN_RELAY, 3'h3);
    chk("own channel", relay_coil[2:1], 2'h1);
    single_a <= 1'h1;
    repeat (4) @(negedge clk);
    chk("shared channel", relay_coil[2], 1'h1);
    single_a <= 1'h0;
    want[3].present <= 1'h0;
    repeat (4) @(negedge clk);
    chk("no module", line_msg[3], MSG_NONE);
    sel(FN_PROT, 3'h3);
    chk("no module other mode", line_msg[3], MSG_NONE);
    want[3].present <= 1'h1;
    sel(FN_PRESS, 3'h0);
    for (int i = 0; i < 7; i++) begin
      @(posedge clk);
      want[mch[i]][21:16] <= mfl[i];
      repeat (4) @(negedge clk);
      chk("line message", line_msg[mch[i]], mexp[i]);
      @(posedge clk);
      want[mch[i]][21:16] <= 6'h00;
    end
    want[1].press <= 16'h8000;
    sel(FN_LEAK, 3'h4);
    chk("leak refused", line_msg[4], MSG_NONE);
    sel(FN_LEAK, 3'h1);
    tap(4'h0, 4'h2);
    want[1].press <= 16'h8005;
    repeat (4) @(negedge clk);
    chk("bar graph", bar_graph, 26'hE000);
    tap(4'h0, 4'h1);
    axi_rd(ADDR_STATUS);
    chk("beeper on", rd[5:2], 4'h5);
    // three lit segments give a period of eight cycles, half of it sounding
    n = 0;
    repeat (16) begin
      @(negedge clk);
      n += int'(beep_out);
    end
    chk("beep duty", n, 8);
    want[1].press <= 16'h0050;
    repeat (4) @(negedge clk);
    chk("leak relay", relay_coil[1], 1'h1);
    sel(FN_PRESS, SEL_BOTTOM);
    put(4'h8, 2);
    repeat (4) tap(4'h8, 4'h4);
    chk("lock status", line_msg[0], MSG_FREE);
    put(4'h4, 2);
    tap(4'h4, 4'h8);
    chk("locked", remote, 1'h1);
    chk("suspended", {proc_suspend, relay_coil[1]}, 2'h3);
    tap(4'h4, 4'h8);
    chk("single toggle", remote, 1'h1);
    put(4'h0, 2);
    chk("resumed", proc_suspend, 1'h0);
    tap(4'h0, 4'h8);
    sel(FN_RELAY, 3'h0);
    axi_rd(ADDR_STATUS);
    chk("forced mode", {rd[5:4], rd[0]}, 3'h1);
    axi_wr(ADDR_CTRL, 32'h3);
    sel(FN_LEAK, 3'h1);
    reset <= 1'h1;
    repeat (2) @(posedge clk);
    reset <= 1'h0;
    repeat (2) @(negedge clk);
    chk("power-on locks", {cal_lock, comm_lock}, 2'h0);
    give_verdict();
  end
endmodule : tb_gsp_panel_logic
